// ### hw/bdm_consts.vh
// Constants of the banked data memory addressing block.
// Included by the data memory module only; holds definitions only.
`ifndef BDM_CONSTS_VH
`define BDM_CONSTS_VH
`define BDM_ADDR_IND0 8'h00
`define BDM_ADDR_PTR0 8'h01
`define BDM_ADDR_IND1 8'h02
`define BDM_ADDR_PTR1 8'h03
`define BDM_ADDR_BANK 8'h04
`define BDM_ADDR_ACC 8'h05
`define BDM_ADDR_EEC 8'h40
`define BDM_BANK_BIT 0
`define BDM_BANK_RESET 1'b0
`define BDM_GP_START_SMALL 8'h80
`define BDM_GP_START_LARGE 8'hA0
`define BDM_ZERO_BYTE 8'h00
`endif

// ### hw/bdm_data_mem.v
// Data memory addressing of an 8-bit core: special function area,
// two banks, two pointer/port pairs and the accumulator path.
// Assumes the core issues one access per cycle on the same clock; the
// peripheral register interface answers sfr reads combinationally.
// How it works
// - Data memory is volatile byte-wide RAM
// - Split into special function and general areas
// - Protected special registers ignore program writes
// - Special locations same all banks, except 40H
// - Addressing starts at 00H, registers first
// - General RAM ranges depend on variant
// - Indirect ports redirect to pointer location
// - Pair zero bank 0; pair one bank bit
// - Indirect access to a port reads zero
// - Pointers are real readable writable registers
// - Direct access targets bank 0, except port 02H which uses the bank bit
// - Bank bit 0 picks indirect bank
// - Reset clears bank; sleep watchdog keeps it
// - Bank bits 7..1 read zero, ignored
// - Accumulator holds results, transfers pass through
`timescale 1ns/1ns
`default_nettype none
`include "bdm_consts.vh"
module bdm_data_mem #(
   parameter LARGE_VARIANT = 1
) (
   // Clock and reset
   input wire ref_clk_in,
   input wire arst_n_in,
   input wire wdt_sleep_reset_in,
   // Core access port
   input wire acc_req_in,
   input wire acc_wr_in,
   input wire acc_ind_in,
   input wire acc_pair_in,
   input wire [7:0] acc_addr_in,
   input wire [7:0] acc_wdata_in,
   output reg [7:0] acc_rdata_out,
   output reg acc_rvalid_out,
   // Accumulator load from the ALU
   input wire alu_load_in,
   input wire [7:0] alu_result_in,
   output reg [7:0] accumulator_out,
   // Peripheral special function registers
   input wire [7:0] sfr_rdata_in,
   input wire [7:0] sfr_protect_in,
   output reg sfr_wr_out,
   output reg sfr_bank1_out,
   output reg [7:0] sfr_addr_out,
   output reg [7:0] sfr_wdata_out,
   output reg bank_select_bit_out
);
   reg [7:0] pointer_zero_reg;
   reg [7:0] pointer_one_reg;
   reg bank_select_reg;
   reg [7:0] accumulator_reg;

   reg [7:0] eff_addr;
   reg eff_bank;
   reg port_target;
   reg is_gp;
   reg is_eec;
   reg is_prot;
   reg ram_we;
   reg [7:0] rd_mux;
   wire [7:0] ram_rdata;
   reg wr_go;
   reg sfr_go;
   reg sfr_wr_next;

   // RAM geometry: bank bit on top of the in-bank location
   localparam DATA_W = 8;
   localparam RAM_AW = 9;

   // The watchdog indication comes from another domain
   localparam SYNC_STAGES = 2;
   reg [SYNC_STAGES-1:0] wdt_sync_reg;
   wire [SYNC_STAGES-1:0] wdt_sync_next;
   reg wdt_seen_reg;
   wire wdt_pulse;

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_STAGES; gi = gi + 1) begin : g_sync
         if (gi == 0) begin : g_first
            assign wdt_sync_next[gi] = wdt_sleep_reset_in;
         end else begin : g_rest
            assign wdt_sync_next[gi] = wdt_sync_reg[gi-1];
         end
         always @(posedge ref_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               wdt_sync_reg[gi] <= 1'b0;
            end else begin
               wdt_sync_reg[gi] <= wdt_sync_next[gi];
            end
         end
      end
   endgenerate

   // One pulse per watchdog event
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wdt_seen_reg <= 1'b0;
      end else begin
         wdt_seen_reg <= wdt_sync_reg[SYNC_STAGES-1];
      end
   end
   assign wdt_pulse = wdt_sync_reg[SYNC_STAGES-1] && !wdt_seen_reg;

   // Indirect port locations hold no storage
   function is_port_addr;
      input [7:0] a;
      begin
         is_port_addr = (a == `BDM_ADDR_IND0) || (a == `BDM_ADDR_IND1);
      end
   endfunction

   // Write strobe for one core register
   function reg_hit;
      input go;
      input gp;
      input [7:0] a;
      input [7:0] target;
      begin
         reg_hit = go && !gp && (a == target);
      end
   endfunction

   // General RAM start for this variant
   function is_gp_addr;
      input [7:0] a;
      input bank;
      begin
         if (LARGE_VARIANT != 0) begin
            is_gp_addr = (a >= `BDM_GP_START_LARGE);
         end else begin
            is_gp_addr = (a >= `BDM_GP_START_SMALL) && !bank;
         end
      end
   endfunction

   // Core-owned registers at the bottom of the special area
   function is_core_reg;
      input [7:0] a;
      begin
         is_core_reg = (a <= `BDM_ADDR_ACC);
      end
   endfunction

   // Effective address and bank resolution
   always @* begin
      eff_addr = acc_addr_in;
      eff_bank = 1'b0;
      port_target = 1'b0;
      if (acc_ind_in) begin
         if (acc_pair_in) begin
            eff_addr = pointer_one_reg;
            eff_bank = bank_select_reg;
         end else begin
            eff_addr = pointer_zero_reg;
            eff_bank = 1'b0;
         end
         port_target = is_port_addr(eff_addr);
      end else if (acc_addr_in == `BDM_ADDR_IND0) begin
         eff_addr = pointer_zero_reg;
         eff_bank = 1'b0;
         port_target = is_port_addr(eff_addr);
      end else if (acc_addr_in == `BDM_ADDR_IND1) begin
         eff_addr = pointer_one_reg;
         eff_bank = bank_select_reg;
         port_target = is_port_addr(eff_addr);
      end
   end

   // Classification of the resolved location
   always @* begin
      is_gp = is_gp_addr(eff_addr, eff_bank);
      is_eec = (eff_addr == `BDM_ADDR_EEC);
      is_prot = 1'b0;
      if (!is_gp && !is_core_reg(eff_addr)) begin
         is_prot = sfr_protect_in[0];
      end
      ram_we = acc_req_in && acc_wr_in && is_gp && !port_target;
   end

   bdm_gp_ram #(
      .DATA_W(DATA_W),
      .ADDR_W(RAM_AW)
   ) u_ram (
      .ref_clk_in(ref_clk_in),
      .wr_en_in(ram_we),
      .addr_in({eff_bank, eff_addr}),
      .wr_data_in(acc_wdata_in),
      .rd_data_out(ram_rdata)
   );

   // Read data selection
   always @* begin
      rd_mux = `BDM_ZERO_BYTE;
      if (port_target) begin
         rd_mux = `BDM_ZERO_BYTE;
      end else if (is_gp) begin
         rd_mux = ram_rdata;
      end else begin
         case (eff_addr)
            `BDM_ADDR_IND0: rd_mux = `BDM_ZERO_BYTE;
            `BDM_ADDR_IND1: rd_mux = `BDM_ZERO_BYTE;
            `BDM_ADDR_PTR0: rd_mux = pointer_zero_reg;
            `BDM_ADDR_PTR1: rd_mux = pointer_one_reg;
            `BDM_ADDR_BANK: rd_mux = {7'h00, bank_select_reg};
            `BDM_ADDR_ACC: rd_mux = accumulator_reg;
            default: begin
               if (is_eec && !eff_bank) begin
                  rd_mux = sfr_rdata_in; // Bank 0 sees the shared register here
               end else begin
                  rd_mux = sfr_rdata_in;
               end
            end
         endcase
      end
   end

   // Write qualification: ports, protection and the bank 1 only byte
   always @* begin
      wr_go = acc_req_in && acc_wr_in && !port_target;
      sfr_go = 1'b0;
      sfr_wr_next = 1'b0;
      if (wr_go && !is_gp && !is_core_reg(eff_addr)) begin
         sfr_go = !is_prot;
      end
      if (sfr_go) begin
         if (is_eec) begin
            sfr_wr_next = eff_bank;
         end else begin
            sfr_wr_next = 1'b1;
         end
      end
   end

   // Pointer zero; a sleep watchdog reset clears it
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pointer_zero_reg <= 8'h00;
      end else if (wdt_pulse) begin
         pointer_zero_reg <= 8'h00;
      end else if (reg_hit(wr_go, is_gp, eff_addr, `BDM_ADDR_PTR0)) begin
         pointer_zero_reg <= acc_wdata_in;
      end
   end

   // Pointer one; a sleep watchdog reset clears it
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pointer_one_reg <= 8'h00;
      end else if (wdt_pulse) begin
         pointer_one_reg <= 8'h00;
      end else if (reg_hit(wr_go, is_gp, eff_addr, `BDM_ADDR_PTR1)) begin
         pointer_one_reg <= acc_wdata_in;
      end
   end

   // Bank bit; a sleep watchdog reset leaves it alone
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bank_select_reg <= `BDM_BANK_RESET;
      end else if (reg_hit(wr_go, is_gp, eff_addr, `BDM_ADDR_BANK)) begin
         bank_select_reg <= acc_wdata_in[`BDM_BANK_BIT];
      end
   end

   // Accumulator: the ALU wins over a bus write
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         accumulator_reg <= 8'h00;
      end else if (alu_load_in) begin
         accumulator_reg <= alu_result_in;
      end else if (wdt_pulse) begin
         accumulator_reg <= 8'h00;
      end else if (reg_hit(wr_go, is_gp, eff_addr, `BDM_ADDR_ACC)) begin
         accumulator_reg <= acc_wdata_in;
      end
   end

   // Read answer valid for one cycle
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         acc_rvalid_out <= 1'b0;
      end else begin
         acc_rvalid_out <= acc_req_in && !acc_wr_in;
      end
   end

   // Read data held until the next read
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         acc_rdata_out <= 8'h00;
      end else begin
         if (acc_req_in && !acc_wr_in) begin
            acc_rdata_out <= rd_mux;
         end
      end
   end

   // Accumulator view, showing an ALU load in the cycle it lands
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         accumulator_out <= 8'h00;
      end else begin
         accumulator_out <= alu_load_in ? alu_result_in : accumulator_reg;
      end
   end

   // Peripheral write strobe
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sfr_wr_out <= 1'b0;
      end else begin
         sfr_wr_out <= sfr_wr_next;
      end
   end

   // Peripheral location and data registered every cycle, access or not
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sfr_bank1_out <= 1'b0;
         sfr_addr_out <= 8'h00;
         sfr_wdata_out <= 8'h00;
      end else begin
         sfr_bank1_out <= eff_bank;
         sfr_addr_out <= eff_addr;
         sfr_wdata_out <= acc_wdata_in;
      end
   end

   // Bank bit view
   always @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bank_select_bit_out <= 1'b0;
      end else begin
         bank_select_bit_out <= bank_select_reg;
      end
   end
endmodule // bdm_data_mem
`default_nettype wire

// ### hw/bdm_gp_ram.v
// General purpose RAM array of the data memory, both banks in one array.
// Assumes one access per cycle; reads are combinational from the array.
`timescale 1ns/1ns
`default_nettype none
module bdm_gp_ram #(
   parameter DATA_W = 8,
   parameter ADDR_W = 8
) (
   // Clock
   input wire ref_clk_in,
   // Access
   input wire wr_en_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire [DATA_W-1:0] wr_data_in,
   output wire [DATA_W-1:0] rd_data_out
);
   // Volatile byte cells, no reset
   reg [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

   always @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem_reg[addr_in] <= wr_data_in;
      end
   end

   assign rd_data_out = mem_reg[addr_in];
endmodule // bdm_gp_ram
`default_nettype wire

// ### verif/banked_data_memory_addressing_tb_top.sv
// Bench for the data memory addressing block with a peripheral model.
// Core requests are driven one at a time by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none
module banked_data_memory_addressing_tb_top;
   logic ref_clk_in = 1'b0, arst_n_in = 1'b0, wdt_sleep_reset_in = 1'b0, acc_req_in = 1'b0;
   logic acc_wr_in = 1'b0, acc_ind_in = 1'b0, acc_pair_in = 1'b0, alu_load_in = 1'b0;
   logic [7:0] acc_addr_in = 8'h00, acc_wdata_in = 8'h00, alu_result_in = 8'h00;
   logic [7:0] acc_rdata_out, accumulator_out, sfr_rdata_in, sfr_protect_in, sfr_addr_out;
   logic [7:0] sfr_wdata_out;
   logic acc_rvalid_out, sfr_wr_out, sfr_bank1_out, bank_select_bit_out;
   int fails = 0, checks_done = 0;
   always #50 ref_clk_in = ~ref_clk_in;
   bdm_data_mem #(.LARGE_VARIANT(1)) dut (.*);
   bdm_sfr_model pm (.clk_in(ref_clk_in), .wr_in(sfr_wr_out), .bank1_in(sfr_bank1_out),
      .sel_in(acc_addr_in), .addr_in(sfr_addr_out), .wdata_in(sfr_wdata_out),
      .rdata_out(sfr_rdata_in), .protect_out(sfr_protect_in));
   task automatic chk(input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, i, p, input logic [7:0] a, d);
      @(posedge ref_clk_in);
      acc_req_in <= 1'b1;
      acc_wr_in <= w;
      acc_ind_in <= i;
      acc_pair_in <= p;
      acc_addr_in <= a;
      acc_wdata_in <= d;
      @(posedge ref_clk_in);
      acc_req_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic i, p, input logic [7:0] a, exp);
      xfer(1'b0, i, p, a, 8'h00);
      chk(acc_rdata_out, exp);
   endtask
   task automatic t_reset;
      chk({7'h00, bank_select_bit_out}, 8'h00);
      rd(0, 0, 8'h04, 8'h00);
   endtask
   task automatic t_regs;
      xfer(1, 0, 0, 8'h01, 8'hA5);
      rd(0, 0, 8'h01, 8'hA5);
      xfer(1, 0, 0, 8'h04, 8'hFF);
      rd(0, 0, 8'h04, 8'h01);
      chk({7'h00, bank_select_bit_out}, 8'h01);
   endtask
   task automatic t_banks;
      xfer(1, 0, 0, 8'h01, 8'hA0);
      xfer(1, 0, 0, 8'h03, 8'hA0);
      xfer(1, 1, 0, 8'h00, 8'h11);
      xfer(1, 0, 0, 8'h02, 8'h22);
      rd(0, 0, 8'hA0, 8'h11);
      rd(1, 1, 8'h00, 8'h22);
      rd(0, 0, 8'h00, 8'h11);
      xfer(1, 0, 0, 8'h04, 8'h00);
      rd(0, 0, 8'h02, 8'h11);
   endtask
   task automatic t_self;
      xfer(1, 0, 0, 8'h01, 8'h02);
      xfer(1, 1, 0, 8'h00, 8'h77);
      rd(0, 0, 8'h00, 8'h00);
      rd(1, 0, 8'h00, 8'h00);
      rd(0, 0, 8'h03, 8'hA0);
      rd(0, 0, 8'hA0, 8'h11);
   endtask
   task automatic t_sfr;
      xfer(1, 0, 0, 8'h20, 8'h3C);
      rd(0, 0, 8'h20, 8'h3C);
      xfer(1, 0, 0, 8'h0A, 8'h55);
      rd(0, 0, 8'h0A, 8'h0A);
      xfer(1, 0, 0, 8'h40, 8'h5E);
      xfer(1, 0, 0, 8'h03, 8'h40);
      xfer(1, 0, 0, 8'h04, 8'h01);
      xfer(1, 1, 1, 8'h00, 8'h5E);
      @(posedge ref_clk_in);
      #1;
      chk(pm.mem[8'h40], 8'h40);
      chk(pm.eec_reg, 8'h5E);
   endtask
   task automatic t_alu;
      @(posedge ref_clk_in);
      alu_load_in <= 1'b1;
      alu_result_in <= 8'h9C;
      @(posedge ref_clk_in);
      alu_load_in <= 1'b0;
      #1;
      chk(accumulator_out, 8'h9C);
      rd(0, 0, 8'h05, 8'h9C);
   endtask
   task automatic t_wdt;
      xfer(1, 0, 0, 8'h04, 8'h01);
      @(posedge ref_clk_in);
      wdt_sleep_reset_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      wdt_sleep_reset_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk({7'h00, bank_select_bit_out}, 8'h01);
      rd(0, 0, 8'h04, 8'h01);
   endtask
   task automatic final_report;
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      t_reset;
      t_regs;
      t_banks;
      t_self;
      t_sfr;
      t_alu;
      t_wdt;
      @(posedge ref_clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      t_reset;
      final_report;
   end
   initial begin
      #100000;
      fails++;
      final_report;
   end
endmodule // banked_data_memory_addressing_tb_top
bind bdm_data_mem bdm_checker u_chk (.*);
`default_nettype wire

// ### verif/bdm_checker.sv
// Port assertions for the data memory addressing block.
// Bound to bdm_data_mem from the bench top; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module bdm_checker (
   // Clock, reset and control inputs
   input wire logic ref_clk_in, arst_n_in, acc_req_in, acc_wr_in, acc_ind_in, alu_load_in,
   input wire logic [7:0] acc_addr_in, acc_wdata_in, alu_result_in, sfr_protect_in,
   // Observed outputs
   input wire logic acc_rvalid_out, sfr_wr_out, bank_select_bit_out,
   input wire logic [7:0] acc_rdata_out, accumulator_out, sfr_addr_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_rd;
      acc_req_in && !acc_wr_in;
   endsequence
   sequence s_dwr(a);
      acc_req_in && acc_wr_in && !acc_ind_in && acc_addr_in == a;
   endsequence
   a_read_answer: assert property (s_rd |=> acc_rvalid_out)
      else $error("read not answered");
   a_no_stray: assert property (!(acc_req_in && !acc_wr_in) |=> !acc_rvalid_out)
      else $error("stray read answer");
   a_bank_write: assert property (s_dwr(8'h04) |=> ##1 bank_select_bit_out == $past(acc_wdata_in[0], 2))
      else $error("bank bit not written");
   a_bank_hold: assert property (!(acc_req_in && acc_wr_in) ##1 !(acc_req_in && acc_wr_in)
      |=> $stable(bank_select_bit_out))
      else $error("bank bit moved");
   a_bank_upper: assert property (s_rd ##0 (!acc_ind_in && acc_addr_in == 8'h04)
      |=> acc_rdata_out[7:1] == 7'h00)
      else $error("bank upper bits not zero");
   a_sfr_write: assert property (acc_req_in && acc_wr_in && !acc_ind_in && !sfr_protect_in[0]
      && acc_addr_in inside {[8'h06:8'h3F], [8'h41:8'h7F]}
      |=> sfr_wr_out && sfr_addr_out == $past(acc_addr_in))
      else $error("sfr write lost");
   a_sfr_protect: assert property (acc_req_in && acc_wr_in && sfr_protect_in[0] |=> !sfr_wr_out)
      else $error("protected write passed");
   a_eec_bank0: assert property (s_dwr(8'h40) |=> !sfr_wr_out)
      else $error("control byte reached in bank 0");
   a_alu_load: assert property (alu_load_in |=> accumulator_out == $past(alu_result_in))
      else $error("accumulator not loaded");
endmodule // bdm_checker
`default_nettype wire

// ### verif/bdm_sfr_model.sv
// Peripheral register side: a byte array plus the bank 1 control byte.
// Answers combinationally from the current access address.
`timescale 1ns/1ns
`default_nettype none
module bdm_sfr_model #(parameter [7:0] PROT_ADDR = 8'h0A) (
   input wire logic clk_in, wr_in, bank1_in,
   input wire logic [7:0] sel_in, addr_in, wdata_in,
   output logic [7:0] rdata_out, protect_out
);
   logic [7:0] mem [0:255];
   logic [7:0] eec_reg = 8'h00;
   assign rdata_out = mem[sel_in];
   assign protect_out = {7'h00, sel_in == PROT_ADDR};
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
   always @(posedge clk_in) begin
      if (wr_in && bank1_in && addr_in == 8'h40) eec_reg <= wdata_in;
      else if (wr_in) mem[addr_in] <= wdata_in;
   end
endmodule // bdm_sfr_model
`default_nettype wire
